// ===== ssalu_pkg.sv
package ssalu_pkg;

  // ---------------------------------------------------------------------------
  // Operation codes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SSALU_OP_NONE,
    SSALU_OP_SUB_MEM,
    SSALU_OP_SUB_TO_MEM,
    SSALU_OP_SUB_IMM,
    SSALU_OP_SWAP_MEM
  } ssalu_op_t;

  // ---------------------------------------------------------------------------
  // Widths, field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned SSALU_DW       = 8;
  localparam int unsigned SSALU_AW       = 8;
  localparam int unsigned SSALU_NIB_HI   = 7;
  localparam int unsigned SSALU_NIB_MID  = 4;
  localparam int unsigned SSALU_NIB_LO   = 3;
  localparam logic [7:0]  SSALU_WREG_RST = 8'h00;
  localparam logic        SSALU_FLAG_RST = 1'b0;
  localparam logic        SSALU_NO_BORROW = 1'b1;

endpackage

// ===== ssalu_sub8.sv
`timescale 1ns/1ps

// Eight-bit subtractor with borrow-style status outputs.
module ssalu_sub8 (
  input  wire logic [7:0] minuend_i,
  input  wire logic [7:0] subtrahend_i,
  output logic      [7:0] diff_o,
  output logic            carry_o,
  output logic            nib_carry_o,
  output logic            ovf_o,
  output logic            zero_o
);

  logic [8:0] full_diff;
  logic [4:0] low_diff;

  // Wide subtraction keeps the borrow in the top bit.
  assign full_diff   = {1'b0, minuend_i} - {1'b0, subtrahend_i};
  assign low_diff    = {1'b0, minuend_i[3:0]} - {1'b0, subtrahend_i[3:0]};
  assign diff_o      = full_diff[7:0];
  assign carry_o     = ~full_diff[8];
  assign nib_carry_o = ~low_diff[4];
  // Signed overflow: operands differ in sign and result sign follows subtrahend.
  assign ovf_o  = (minuend_i[7] ^ subtrahend_i[7]) &
                  (minuend_i[7] ^ full_diff[7]);
  assign zero_o = (full_diff[7:0] == 8'h00);

endmodule // ssalu_sub8

// ===== ssalu_top.sv
`timescale 1ns/1ps

// Summary of operation
// - Subtract-memory loads the register minus the byte, with flags.
// - Subtract-to-memory writes the difference back; register unchanged.
// - Each subtraction sets carry 0 on a borrow and 1 otherwise.
// - Subtract-immediate loads register minus constant, with flags.
// - Nibble swap writes the halves exchanged back and keeps all flags.
module ssalu_top
  import ssalu_pkg::*;
(
  // Clock and reset.
  input  wire logic                SYS_CLK_I,
  input  wire logic                SYS_RST_I,
  // Instruction request.
  input  wire logic                OP_VALID_I,
  input  wire ssalu_op_t           OP_CODE_I,
  input  wire logic [SSALU_AW-1:0] OP_ADDR_I,
  input  wire logic [SSALU_DW-1:0] OP_IMM_I,
  // Data memory operand read by the core.
  input  wire logic [SSALU_DW-1:0] MEM_RDATA_I,
  // Data memory write-back.
  output logic                     MEM_WE_O,
  output logic      [SSALU_AW-1:0] MEM_WADDR_O,
  output logic      [SSALU_DW-1:0] MEM_WDATA_O,
  // Architectural state.
  output logic      [SSALU_DW-1:0] WORKING_REGISTER_O,
  output logic                     CARRY_O,
  output logic                     ZERO_O,
  output logic                     NIBBLE_BORROW_BIT_O,
  output logic                     SIGNED_RANGE_BIT_O
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  // The register value is always the minuend of the shared subtractor.
  logic [SSALU_DW-1:0] working_register_ff;
  logic [SSALU_DW-1:0] nxt_working_register;
  // Operand on offer and the two candidate results.
  logic [SSALU_DW-1:0] sub_rhs;
  logic [SSALU_DW-1:0] diff;
  logic [SSALU_DW-1:0] swapped;
  // Status outputs of the subtractor for the op on offer.
  logic                carry;
  logic                nib_carry;
  logic                ovf;
  logic                zero;
  // Decoded controls, before and after qualification by the valid strobe.
  logic                dec_sub;
  logic                dec_load_wreg;
  logic                dec_write_mem;
  logic                dec_use_imm;
  logic                dec_swap;
  logic                is_sub;
  logic                load_wreg;
  logic                write_mem;
  // Next values of the flag registers.
  logic                nxt_carry;
  logic                nxt_zero;
  logic                nxt_nib_borrow;
  logic                nxt_signed_range;
  // Next values of the write-back registers.
  logic                nxt_mem_we;
  logic [SSALU_AW-1:0] nxt_mem_waddr;
  logic [SSALU_DW-1:0] nxt_mem_wdata;

  // ---------------------------------------------------------------------------
  // Operation decode
  // ---------------------------------------------------------------------------
  // Each code is broken into the few controls that the datapath needs, so the
  // rest of the block never compares codes again. Idle and unused codes
  // decode to no action at all.
  always_comb begin
    dec_sub       = 1'b0;
    dec_load_wreg = 1'b0;
    dec_write_mem = 1'b0;
    dec_use_imm   = 1'b0;
    dec_swap      = 1'b0;
    case (OP_CODE_I)
      SSALU_OP_SUB_MEM: begin
        dec_sub       = 1'b1;
        dec_load_wreg = 1'b1;
      end
      SSALU_OP_SUB_TO_MEM: begin
        dec_sub       = 1'b1;
        dec_write_mem = 1'b1;
      end
      SSALU_OP_SUB_IMM: begin
        dec_sub       = 1'b1;
        dec_load_wreg = 1'b1;
        dec_use_imm   = 1'b1;
      end
      SSALU_OP_SWAP_MEM: begin
        dec_write_mem = 1'b1;
        dec_swap      = 1'b1;
      end
      default: begin
        dec_sub       = 1'b0;
      end
    endcase
  end

  // Nothing happens unless the core marks the code as valid this cycle.
  assign is_sub    = OP_VALID_I && dec_sub;
  assign load_wreg = OP_VALID_I && dec_load_wreg;
  assign write_mem = OP_VALID_I && dec_write_mem;

  // ---------------------------------------------------------------------------
  // Operand selection and arithmetic
  // ---------------------------------------------------------------------------
  // The immediate form takes the constant, the others take the memory byte.
  assign sub_rhs = dec_use_imm ? OP_IMM_I : MEM_RDATA_I;

  // Halves exchanged for the swap; the byte is used as read this cycle.
  assign swapped = {MEM_RDATA_I[SSALU_NIB_LO:0],
                    MEM_RDATA_I[SSALU_NIB_HI:SSALU_NIB_MID]};

  // One subtractor serves all three subtract forms, which keeps the flag
  // logic identical for every one of them.
  ssalu_sub8 u_sub (
    .minuend_i    (working_register_ff),
    .subtrahend_i (sub_rhs),
    .diff_o       (diff),
    .carry_o      (carry),
    .nib_carry_o  (nib_carry),
    .ovf_o        (ovf),
    .zero_o       (zero)
  );

  // ---------------------------------------------------------------------------
  // Working register
  // ---------------------------------------------------------------------------
  // Next value: the difference for register-destination forms, else hold.
  always_comb begin
    nxt_working_register = working_register_ff;
    if (load_wreg) begin
      nxt_working_register = diff;
    end
  end

  // The subtract-to-memory form leaves the register as it was.
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      working_register_ff <= SSALU_WREG_RST;
    end else begin
      working_register_ff <= nxt_working_register;
    end
  end

  // The port shows the register itself, with no logic after the flop.
  assign WORKING_REGISTER_O = working_register_ff;

  // ---------------------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------------------
  // Subtractions take all four flags from the subtractor; every other op,
  // the swap included, leaves them untouched.
  always_comb begin
    nxt_carry        = CARRY_O;
    nxt_zero         = ZERO_O;
    nxt_nib_borrow   = NIBBLE_BORROW_BIT_O;
    nxt_signed_range = SIGNED_RANGE_BIT_O;
    if (is_sub) begin
      nxt_carry        = carry;
      nxt_zero         = zero;
      nxt_nib_borrow   = nib_carry;
      nxt_signed_range = ovf;
    end
  end

  // Carry is 1 when no borrow left bit 7.
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      CARRY_O <= SSALU_FLAG_RST;
    end else begin
      CARRY_O <= nxt_carry;
    end
  end

  // Zero is 1 when all eight result bits are clear.
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ZERO_O <= SSALU_FLAG_RST;
    end else begin
      ZERO_O <= nxt_zero;
    end
  end

  // The nibble flag is 1 when no borrow left bit 3.
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      NIBBLE_BORROW_BIT_O <= SSALU_FLAG_RST;
    end else begin
      NIBBLE_BORROW_BIT_O <= nxt_nib_borrow;
    end
  end

  // The range flag is 1 when the signed difference does not fit.
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      SIGNED_RANGE_BIT_O <= SSALU_FLAG_RST;
    end else begin
      SIGNED_RANGE_BIT_O <= nxt_signed_range;
    end
  end

  // ---------------------------------------------------------------------------
  // Memory write-back
  // ---------------------------------------------------------------------------
  // The strobe is a one-cycle pulse after each memory-destination op, while
  // address and data hold until the next such op replaces them.
  always_comb begin
    nxt_mem_we    = 1'b0;
    nxt_mem_waddr = MEM_WADDR_O;
    nxt_mem_wdata = MEM_WDATA_O;
    if (write_mem) begin
      nxt_mem_we    = 1'b1;
      nxt_mem_waddr = OP_ADDR_I;
      if (dec_swap) begin
        nxt_mem_wdata = swapped;
      end else begin
        nxt_mem_wdata = diff;
      end
    end
  end

  // Write strobe register.
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      MEM_WE_O <= SSALU_FLAG_RST;
    end else begin
      MEM_WE_O <= nxt_mem_we;
    end
  end

  // Write address register.
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      MEM_WADDR_O <= SSALU_WREG_RST;
    end else begin
      MEM_WADDR_O <= nxt_mem_waddr;
    end
  end

  // Write data register.
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      MEM_WDATA_O <= SSALU_WREG_RST;
    end else begin
      MEM_WDATA_O <= nxt_mem_wdata;
    end
  end

endmodule // ssalu_top

// ===== ssalu_top_checker.sv
`timescale 1ns/1ps
// Watches the results one cycle after each accepted op.
module ssalu_top_checker
  import ssalu_pkg::*;
(
  // Ports of the watched block.
  input wire logic                SYS_CLK_I,
  input wire logic                SYS_RST_I,
  input wire logic                OP_VALID_I,
  input wire ssalu_op_t           OP_CODE_I,
  input wire logic [SSALU_DW-1:0] OP_IMM_I,
  input wire logic [SSALU_DW-1:0] MEM_RDATA_I,
  input wire logic                MEM_WE_O,
  input wire logic [SSALU_DW-1:0] MEM_WDATA_O,
  input wire logic [SSALU_DW-1:0] WORKING_REGISTER_O,
  input wire logic                CARRY_O,
  input wire logic                ZERO_O,
  input wire logic                NIBBLE_BORROW_BIT_O,
  input wire logic                SIGNED_RANGE_BIT_O
);
  // Expected results of the op on offer, from its operands.
  wire logic       is_sub = OP_VALID_I && OP_CODE_I inside {SSALU_OP_SUB_MEM,
                            SSALU_OP_SUB_TO_MEM, SSALU_OP_SUB_IMM};
  wire logic [7:0] opnd   = (OP_CODE_I == SSALU_OP_SUB_IMM) ? OP_IMM_I
                                                             : MEM_RDATA_I;
  wire logic [7:0] dif    = WORKING_REGISTER_O - opnd;
  wire logic       nob    = WORKING_REGISTER_O >= opnd;
  wire logic       nib    = WORKING_REGISTER_O[3:0] >= opnd[3:0];
  wire logic       ovf    = (WORKING_REGISTER_O[7] ^ opnd[7]) &
                            (WORKING_REGISTER_O[7] ^ dif[7]);
  wire logic [7:0] swp    = {MEM_RDATA_I[3:0], MEM_RDATA_I[7:4]};
  wire logic [3:0] flg    = {CARRY_O, ZERO_O, NIBBLE_BORROW_BIT_O,
                             SIGNED_RANGE_BIT_O};
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  wreg_sub_a: assert property (
    is_sub && OP_CODE_I != SSALU_OP_SUB_TO_MEM
    |=> WORKING_REGISTER_O == $past(dif)) else $error("Bad working reg.");
  mem_sub_a: assert property (
    OP_VALID_I && OP_CODE_I == SSALU_OP_SUB_TO_MEM
    |=> MEM_WE_O && MEM_WDATA_O == $past(dif) && $stable(WORKING_REGISTER_O))
    else $error("Bad memory difference.");
  carry_flag_a: assert property (is_sub |=> CARRY_O == $past(nob))
    else $error("Bad carry.");
  swap_write_a: assert property (
    OP_VALID_I && OP_CODE_I == SSALU_OP_SWAP_MEM
    |=> MEM_WE_O && MEM_WDATA_O == $past(swp)) else $error("Bad swap.");
  flag_hold_a: assert property (!is_sub |=> $stable(flg))
    else $error("Flags moved.");
  zero_flag_a: assert property (
    is_sub |=> ZERO_O == ($past(dif) == 8'h00))
    else $error("Bad zero.");
  nib_flag_a: assert property (
    is_sub |=> NIBBLE_BORROW_BIT_O == $past(nib))
    else $error("Bad nibble flag.");
  ovf_flag_a: assert property (
    is_sub |=> SIGNED_RANGE_BIT_O == $past(ovf))
    else $error("Bad overflow.");
endmodule // ssalu_top_checker

bind ssalu_top ssalu_top_checker i_ssalu_top_checker (.*);

// ===== tb.sv
`timescale 1ns/1ps
// Random ops each cycle, checked against an integer model.
module tb;
  import ssalu_pkg::*;
  logic       clk = 0, rst = 1, vld = 0, we, c, z, ac, ov;
  ssalu_op_t  op = SSALU_OP_NONE;
  logic [7:0] adr = 0, imm = 0, rd = 0, wa, wd, wr, w = 0, ewa = 0, ewd = 0;
  logic       ec = 0, ez = 0, ea = 0, eo = 0, ewe = 0;
  int         n_fail = 0, tests_run = 0, seed = 32'h3885, b, r;
  ssalu_top i_ssalu_top (.SYS_CLK_I(clk), .SYS_RST_I(rst), .OP_VALID_I(vld),
    .OP_CODE_I(op), .OP_ADDR_I(adr), .OP_IMM_I(imm), .MEM_RDATA_I(rd),
    .MEM_WE_O(we), .MEM_WADDR_O(wa), .MEM_WDATA_O(wd),
    .WORKING_REGISTER_O(wr), .CARRY_O(c), .ZERO_O(z),
    .NIBBLE_BORROW_BIT_O(ac), .SIGNED_RANGE_BIT_O(ov));
  // Compares one value and counts it.
  task chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Prints the verdict and ends the run.
  task test_done;
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Clock and watchdog.
  initial forever #2.5 clk = ~clk;
  initial begin
    #20000 n_fail++;
    test_done;
  end
  // Checks last results, then offers a new op and steps the model.
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 0;
    repeat (2000) begin
      @(posedge clk);
      #1;
      chk(wr, w);
      chk({7'h00, c}, {7'h00, ec});
      chk({5'h00, z, ac, ov}, {5'h00, ez, ea, eo});
      chk({7'h00, we}, {7'h00, ewe});
      chk(wd, ewd);
      chk(wa, ewa);
      vld = ($random(seed) % 4) != 0;
      op = ssalu_op_t'($unsigned($random(seed)) % 5);
      adr = $random(seed);
      imm = $random(seed);
      rd = $random(seed);
      ewe = 0;
      b = (op == SSALU_OP_SUB_IMM) ? imm : rd;
      r = w - b;
      if (vld && op inside {SSALU_OP_SUB_MEM, SSALU_OP_SUB_TO_MEM,
                            SSALU_OP_SUB_IMM}) begin
        ec = w >= b;
        ez = r[7:0] == 0;
        ea = w[3:0] >= b[3:0];
        eo = (w[7] ^ b[7]) & (w[7] ^ r[7]);
        if (op != SSALU_OP_SUB_TO_MEM) w = r[7:0];
      end
      if (vld && op inside {SSALU_OP_SUB_TO_MEM, SSALU_OP_SWAP_MEM}) begin
        ewe = 1;
        ewa = adr;
        ewd = (op == SSALU_OP_SWAP_MEM) ? {rd[3:0], rd[7:4]} : r[7:0];
      end
    end
    test_done;
  end
endmodule // tb
